// *** psa_arbiter.sv ***
// PCI system arbiter configuration, parking and grant time-out.
//
// Function
// - Parked master keeps its grant asserted.
// - Others request; arbitration takes two clocks.
// - Parking penalty applies in both modes.
// - Reset returns logic and configuration to defaults.
// - Nonconcurrent mode after reset.
// - Without high queue, request 0 highest, 4 lowest.
// - Reset disables masters except the CPU.
// - Concurrent enable bit selects concurrent mode.
// - Park on CPU, or last master if selected in concurrent mode.
// - Priority register places masters in high queue.
// - External requests pass only when enabled.
// - Time-out sets status bit even masked.
// - Time-out after 16 idle clocks, record master.
// - Time-out never disables the master itself.
module psa_arbiter
    import psa_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Register bus.
    input wire psa_apb_req_s apb_req,
    output psa_apb_rsp_s apb_rsp,
    // External masters and bus state pins.
    input wire logic [4:0] req_n,
    input wire logic frame_n,
    input wire logic irdy_n,
    output logic [4:0] gnt_n,
    // On-chip CPU.
    input wire logic cpu_req,
    output logic cpu_gnt,
    // Interrupt.
    output logic irq
);

    //////////////////////////////////////////////////////////////////////
    // Pin synchronisers.
    logic [6:0] pins_s;
    logic [4:0] req_n_s;
    logic frame_n_s;
    logic irdy_n_s;
    logic bus_idle;

    psa_sync #(.WIDTH(7), .RST_VAL(7'h7f)) u_sync (
        .core_clk(core_clk),
        .reset(reset),
        .d({irdy_n, frame_n, req_n}),
        .q(pins_s)
    );

    assign req_n_s = pins_s[4:0];
    assign frame_n_s = pins_s[5];
    assign irdy_n_s = pins_s[6];
    assign bus_idle = frame_n_s & irdy_n_s;

    //////////////////////////////////////////////////////////////////////
    // Registers.
    logic [7:0] ctrl_r;
    logic [15:0] menb_r;
    logic [31:0] pri_r;
    logic [7:0] ien_r;
    logic stat_to_r;
    logic [2:0] to_id_r;
    logic [7:0] stat_val;
    logic cncr_on;
    logic park_last;
    logic apb_wr;
    logic wr_ctrl;
    logic wr_menb;
    logic wr_pri;
    logic wr_ien;
    logic wr_iclr;
    logic mapped;
    logic [31:0] rd_val;

    assign cncr_on = ctrl_r[CTRL_CNCR_BIT];
    assign park_last = cncr_on & ctrl_r[CTRL_PARK_BIT];
    assign stat_val = {1'b0, to_id_r, 3'h0, stat_to_r};
    assign apb_wr = apb_req.psel & apb_req.penable & apb_req.pwrite &
        apb_rsp.pready;
    assign wr_ctrl = apb_wr & (apb_req.paddr == ADDR_CTRL);
    assign wr_menb = apb_wr & (apb_req.paddr == ADDR_MENB);
    assign wr_pri = apb_wr & (apb_req.paddr == ADDR_PRI);
    assign wr_ien = apb_wr & (apb_req.paddr == ADDR_IEN);
    assign wr_iclr = apb_wr & (apb_req.paddr == ADDR_ICLR);

    always_comb begin
        mapped = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (apb_req.paddr)
            ADDR_CTRL: rd_val = {24'h0, ctrl_r};
            ADDR_STAT: rd_val = {24'h0, stat_val};
            ADDR_MENB: rd_val = {16'h0, menb_r};
            ADDR_PRI: rd_val = pri_r;
            ADDR_IEN: rd_val = {24'h0, ien_r};
            ADDR_ICLR: rd_val = 32'h0000_0000;
            default: mapped = 1'b0;
        endcase
    end

    // Answer one cycle after setup, so the access phase ends at once.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            apb_rsp <= '0;
        end else if (apb_req.psel & ~apb_req.penable & ~apb_rsp.pready) begin
            apb_rsp.pready <= 1'b1;
            apb_rsp.pslverr <= ~mapped;
            apb_rsp.prdata <= apb_req.pwrite ? 32'h0000_0000 : rd_val;
        end else begin
            apb_rsp <= '0;
        end
    end

    // Configuration registers return to defaults on reset.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            ctrl_r <= CTRL_RST;
            menb_r <= MENB_RST;
            pri_r <= PRI_RST;
            ien_r <= IEN_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= apb_req.pwdata[7:0] & 8'h03;
            end
            if (wr_menb) begin
                menb_r <= apb_req.pwdata[15:0] & 16'h801f;
            end
            if (wr_pri) begin
                pri_r <= {27'h0, apb_req.pwdata[4:0]};
            end
            if (wr_ien) begin
                ien_r <= apb_req.pwdata[7:0] & 8'h01;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Request gating and priority.
    logic [4:0] ext_req;
    logic cpu_req_on;
    logic win_v;
    logic [2:0] win_id;

    for (genvar g = 0; g < 5; g++) begin : g_req
        assign ext_req[g] = ~req_n_s[g] & menb_r[g];
    end
    assign cpu_req_on = cpu_req & menb_r[MENB_CPU_BIT];

    // High queue first, then low queue, lower line number first.
    always_comb begin
        win_v = 1'b0;
        win_id = CPU_ID;
        for (int i = 4; i >= 0; i--) begin
            if (ext_req[i] & ~pri_r[i]) begin
                win_v = 1'b1;
                win_id = 3'(i);
            end
        end
        for (int i = 4; i >= 0; i--) begin
            if (ext_req[i] & pri_r[i]) begin
                win_v = 1'b1;
                win_id = 3'(i);
            end
        end
        if (!win_v && cpu_req_on) begin
            win_v = 1'b1;
            win_id = CPU_ID;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Grant state machine.
    psa_state_e st_r;
    psa_state_e st_nxt;
    logic [2:0] owner_r;
    logic [2:0] owner_nxt;
    logic [4:0] to_cnt_r;
    logic to_event;
    logic [5:0] gnt_all;

    assign to_event = (st_r == ST_GRANT) & bus_idle &
        (to_cnt_r == GNT_TIMEOUT_CLKS - 5'h01);
    assign gnt_all = {cpu_gnt, ~gnt_n};

    always_comb begin
        st_nxt = st_r;
        owner_nxt = owner_r;
        unique case (st_r)
            ST_PARK: begin
                if (!frame_n_s) begin
                    st_nxt = ST_BUSY;
                end else if (win_v && win_id != owner_r) begin
                    st_nxt = ST_HAND;
                    owner_nxt = win_id;
                end else if (!park_last) begin
                    owner_nxt = CPU_ID;
                end
            end
            ST_HAND: begin
                st_nxt = ST_GRANT;
            end
            ST_GRANT: begin
                if (!frame_n_s) begin
                    st_nxt = ST_BUSY;
                end else if (to_event) begin
                    st_nxt = ST_PARK;
                    owner_nxt = CPU_ID;
                end
            end
            ST_BUSY: begin
                if (bus_idle) begin
                    st_nxt = ST_PARK;
                    owner_nxt = park_last ? owner_r : CPU_ID;
                end
            end
            default: begin
                st_nxt = ST_PARK;
                owner_nxt = CPU_ID;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            st_r <= ST_PARK;
            owner_r <= CPU_ID;
            gnt_n <= 5'h1f;
            cpu_gnt <= 1'b1;
        end else begin
            st_r <= st_nxt;
            owner_r <= owner_nxt;
            if (st_nxt == ST_HAND) begin
                gnt_n <= 5'h1f;
                cpu_gnt <= 1'b0;
            end else begin
                gnt_n <= ~(5'h01 << owner_nxt);
                cpu_gnt <= (owner_nxt == CPU_ID);
            end
        end
    end

    // Idle clocks counted while a granted master has not started.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            to_cnt_r <= 5'h00;
        end else if (st_r == ST_GRANT && bus_idle && !to_event) begin
            to_cnt_r <= to_cnt_r + 5'h01;
        end else begin
            to_cnt_r <= 5'h00;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Time-out status and interrupt.
    always_ff @(posedge core_clk) begin
        if (reset) begin
            stat_to_r <= 1'b0;
            to_id_r <= 3'h0;
        end else if (to_event) begin
            stat_to_r <= 1'b1;
            to_id_r <= owner_r;
        end else if (wr_iclr && apb_req.pwdata[STAT_TO_BIT]) begin
            stat_to_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= stat_to_r & ien_r[IRQ_TO_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Checks.
    a_park_grant_held: assert property (@(posedge core_clk)
        disable iff (reset)
        st_r == ST_PARK |-> gnt_all == (6'h01 << owner_r))
        else $error("parked master lost its grant");

    a_two_clock_arb: assert property (@(posedge core_clk)
        disable iff (reset)
        (st_r == ST_PARK && frame_n_s && win_v && win_id != owner_r)
        |=> gnt_all == 6'h00 ##1 gnt_all == (6'h01 << $past(win_id, 2)))
        else $error("arbitration did not take two clocks");

    a_reset_defaults: assert property (@(posedge core_clk)
        disable iff (reset)
        $past(reset) |-> ctrl_r == CTRL_RST && menb_r == MENB_RST &&
            pri_r == PRI_RST && ien_r == IEN_RST && !stat_to_r)
        else $error("configuration not at default after reset");

    a_nonconc_cpu_park: assert property (@(posedge core_clk)
        disable iff (reset)
        (st_r == ST_PARK && $past(st_r) == ST_PARK &&
            !$past(cncr_on)) |-> owner_r == CPU_ID && cpu_gnt)
        else $error("nonconcurrent mode parked off the cpu");

    a_req_gated: assert property (@(posedge core_clk)
        disable iff (reset)
        (win_v && win_id != CPU_ID) |-> menb_r[win_id] && ~req_n_s[win_id])
        else $error("disabled request won arbitration");

    a_high_queue_first: assert property (@(posedge core_clk)
        disable iff (reset)
        (win_v && (ext_req & pri_r[4:0]) != 5'h00) |->
            win_id != CPU_ID && pri_r[win_id])
        else $error("high queue master was passed over");

    a_timeout_flag: assert property (@(posedge core_clk)
        disable iff (reset)
        to_event |=> stat_to_r && to_id_r == $past(owner_r))
        else $error("time-out not recorded");

    a_timeout_16: assert property (@(posedge core_clk)
        disable iff (reset)
        to_event |-> $past(bus_idle, 15) && $past(st_r, 15) == ST_GRANT)
        else $error("time-out not after sixteen idle clocks");

    a_no_auto_off: assert property (@(posedge core_clk)
        disable iff (reset)
        (to_event && !wr_menb) |=> $stable(menb_r))
        else $error("time-out changed the master enables");

    a_timeout_to_cpu: assert property (@(posedge core_clk)
        disable iff (reset)
        to_event |=> st_r == ST_PARK && owner_r == CPU_ID && cpu_gnt)
        else $error("time-out did not return the bus to the cpu");

    a_one_grant: assert property (@(posedge core_clk)
        disable iff (reset)
        $onehot0(gnt_all))
        else $error("more than one grant asserted");

    a_irq_level: assert property (@(posedge core_clk)
        disable iff (reset)
        irq == $past(stat_to_r && ien_r[IRQ_TO_BIT]))
        else $error("interrupt does not follow enabled status");

endmodule // psa_arbiter

// *** psa_pci_masters.sv ***
// Behavioural model of the five external bus masters.
module psa_pci_masters (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Grants from the arbiter and commands from the bench.
    input wire logic [4:0] gnt_n,
    input wire logic [4:0] post,
    input wire logic broken,
    // Bus pins; released lines float high on their pull-ups.
    output logic [4:0] req_n,
    output logic frame_n,
    output logic irdy_n
);
    ////////////////////////////////////////
    logic [4:0] pend_r;
    logic [2:0] cnt_r;

    // A master requests until it starts, and starts only once granted.
    assign req_n = ~pend_r;
    assign frame_n = ~(cnt_r > 3'h1);
    assign irdy_n = ~(cnt_r != 3'h0);

    always_ff @(posedge core_clk) begin
        if (reset) begin
            pend_r <= 5'h00;
            cnt_r <= 3'h0;
        end else if (cnt_r != 3'h0) begin
            cnt_r <= cnt_r - 3'h1;
            pend_r <= pend_r | post;
        end else if (!broken && (pend_r & ~gnt_n) != 5'h00) begin
            cnt_r <= 3'h5;
            pend_r <= (pend_r | post) & gnt_n;
        end else begin
            pend_r <= pend_r | post;
        end
    end
endmodule // psa_pci_masters

// *** psa_pkg.sv ***
// Package with register map, field layout, states and bus structs.
package psa_pkg;

    //////////////////////////////////////////////////////////////////////
    // Register indices and byte addresses.
    localparam logic [11:0] IDX_CTRL = 12'h070;
    localparam logic [11:0] IDX_STAT = 12'h071;
    localparam logic [11:0] IDX_MENB = 12'h072;
    localparam logic [11:0] IDX_PRI = 12'h074;
    localparam logic [11:0] IDX_IEN = 12'h078;
    localparam logic [11:0] IDX_ICLR = 12'h079;
    localparam logic [11:0] ADDR_CTRL = {IDX_CTRL[9:0], 2'h0};
    localparam logic [11:0] ADDR_STAT = {IDX_STAT[9:0], 2'h0};
    localparam logic [11:0] ADDR_MENB = {IDX_MENB[9:0], 2'h0};
    localparam logic [11:0] ADDR_PRI = {IDX_PRI[9:0], 2'h0};
    localparam logic [11:0] ADDR_IEN = {IDX_IEN[9:0], 2'h0};
    localparam logic [11:0] ADDR_ICLR = {IDX_ICLR[9:0], 2'h0};

    //////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned CTRL_PARK_BIT = 0;
    localparam int unsigned CTRL_CNCR_BIT = 1;
    localparam int unsigned STAT_TO_BIT = 0;
    localparam int unsigned STAT_ID_LSB = 4;
    localparam int unsigned MENB_CPU_BIT = 15;
    localparam int unsigned IRQ_TO_BIT = 0;

    //////////////////////////////////////////////////////////////////////
    // Reset values and timing.
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] MENB_RST = 16'h8000;
    localparam logic [31:0] PRI_RST = 32'h0000_0000;
    localparam logic [7:0] IEN_RST = 8'h00;
    localparam logic [4:0] GNT_TIMEOUT_CLKS = 5'h10;

    //////////////////////////////////////////////////////////////////////
    // Masters, states and bus carriers.
    localparam logic [2:0] CPU_ID = 3'h5;

    typedef enum logic [3:0] {
        ST_PARK = 4'h1,
        ST_HAND = 4'h2,
        ST_GRANT = 4'h4,
        ST_BUSY = 4'h8
    } psa_state_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } psa_apb_req_s;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } psa_apb_rsp_s;

endpackage

// *** psa_sync.sv ***
// Two flip-flop synchroniser for pin inputs.
module psa_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset,
    // Data.
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge core_clk) begin
        if (reset) begin
            meta_r <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule // psa_sync

// *** testbench.sv ***
// Self-checking testbench for the arbiter setup block.
module testbench import psa_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, cpu_req, cpu_gnt, irq, frame_n, irdy_n, broken;
    logic [4:0] req_n, gnt_n, post, en, hi, r;
    psa_apb_req_s apb_req;
    psa_apb_rsp_s apb_rsp;
    int num_errors = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [31:0] seed, q;
    logic e;

    psa_arbiter DUT (.core_clk(core_clk), .reset(reset),
        .apb_req(apb_req), .apb_rsp(apb_rsp), .req_n(req_n),
        .frame_n(frame_n), .irdy_n(irdy_n), .gnt_n(gnt_n),
        .cpu_req(cpu_req), .cpu_gnt(cpu_gnt), .irq(irq));
    psa_pci_masters masters (.core_clk(core_clk), .reset(reset),
        .gnt_n(gnt_n), .post(post), .broken(broken), .req_n(req_n),
        .frame_n(frame_n), .irdy_n(irdy_n));

    ////////////////////////////////////////
    always #2 core_clk = ~core_clk;

    task end_sim;
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            end_sim();
        end
    end

    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        apb_req <= '{1'b1, 1'b0, w, a, d};
        @(posedge core_clk);
        apb_req.penable <= 1'b1;
        do @(posedge core_clk); while (apb_rsp.pready !== 1'b1);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req <= '0;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        chk(q, x);
    endtask

    function logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Grant expected for a request set: high queue first, low index first.
    function logic [4:0] win(input logic [4:0] rq, input logic [4:0] h);
        logic [4:0] c;
        c = ((rq & h) != 5'h0) ? (rq & h) : rq;
        win = 5'h1f;
        for (int i = 4; i >= 0; i--) begin
            if (c[i]) win = ~(5'h01 << i);
        end
    endfunction

    // Wait for the single cycle with every grant off, then the winner.
    task grant(input logic [5:0] x);
        do @(posedge core_clk); while ({cpu_gnt, gnt_n} !== 6'h1f);
        @(posedge core_clk);
        chk({cpu_gnt, gnt_n}, x);
        @(posedge core_clk);
        chk({cpu_gnt, gnt_n}, x);
    endtask

    task serve(input logic [4:0] rq, input logic [4:0] h);
        post <= rq;
        @(posedge core_clk);
        post <= 5'h0;
        while (rq != 5'h0) begin
            grant({1'b0, win(rq, h)});
            rq = rq & win(rq, h);
        end
    endtask

    task do_reset;
        reset <= 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        rd(ADDR_CTRL, 32'(CTRL_RST));
        rd(ADDR_STAT, 32'h0);
        rd(ADDR_MENB, 32'(MENB_RST));
        rd(ADDR_PRI, PRI_RST);
        rd(ADDR_IEN, 32'(IEN_RST));
        chk({irq, cpu_gnt, gnt_n}, 7'h3f);
    endtask

    ////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        apb_req = '0;
        cpu_req = 1'b0;
        post = 5'h0;
        broken = 1'b0;
        seed = 32'hf5e00ba9;
        do_reset();
        apb(1'b0, 12'h000, 32'h0);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
        apb(1'b1, ADDR_STAT, 32'hff);
        rd(ADDR_STAT, 32'h0);
        post <= 5'h1f;
        @(posedge core_clk);
        post <= 5'h0;
        repeat (30) @(posedge core_clk);
        chk({cpu_gnt, gnt_n}, 6'h3f);
        apb(1'b1, ADDR_MENB, 32'h801f);
        serve(5'h1f, 5'h00);
        repeat (8) begin
            seed = xs(seed);
            hi = seed[4:0];
            en = seed[9:5] | 5'h01;
            r = seed[14:10] & en;
            if (r == 5'h0) r = en;
            apb(1'b1, ADDR_PRI, {27'h0, hi});
            rd(ADDR_PRI, {27'h0, hi});
            apb(1'b1, ADDR_MENB, {16'h0, 1'b1, 10'h0, en});
            serve(r, hi);
            repeat (20) @(posedge core_clk);
        end
        apb(1'b1, ADDR_PRI, 32'h0);
        apb(1'b1, ADDR_CTRL, 32'h1);
        apb(1'b1, ADDR_MENB, 32'h8004);
        serve(5'h04, 5'h0);
        repeat (30) @(posedge core_clk);
        chk({cpu_gnt, gnt_n}, 6'h3f);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_MENB, 32'h8002);
        broken <= 1'b1;
        serve(5'h02, 5'h0);
        repeat (6) @(posedge core_clk);
        rd(ADDR_STAT, 32'h0);
        do @(posedge core_clk); while (cpu_gnt !== 1'b1);
        rd(ADDR_STAT, 32'h11);
        chk(irq, 1'b0);
        rd(ADDR_MENB, 32'h8002);
        apb(1'b1, ADDR_IEN, 32'h1);
        repeat (2) @(posedge core_clk);
        chk(irq, 1'b1);
        broken <= 1'b0;
        repeat (60) @(posedge core_clk);
        apb(1'b1, ADDR_ICLR, 32'h1);
        apb(1'b0, ADDR_STAT, 32'h0);
        chk({irq, q[0]}, 2'h0);
        apb(1'b1, ADDR_MENB, 32'h8000);
        apb(1'b1, ADDR_CTRL, 32'h2);
        rd(ADDR_CTRL, 32'h2);
        apb(1'b1, ADDR_CTRL, 32'h3);
        apb(1'b1, ADDR_MENB, 32'h8008);
        serve(5'h08, 5'h0);
        repeat (40) @(posedge core_clk);
        chk({cpu_gnt, gnt_n}, 6'h17);
        cpu_req <= 1'b1;
        grant(6'h3f);
        repeat (20) @(posedge core_clk);
        cpu_req <= 1'b0;
        rd(ADDR_STAT, 32'h51);
        do_reset();
        end_sim();
    end
endmodule // testbench
